//--- rtl/ddmc_defines.svh
`ifndef DDMC_DEFINES_SVH
`define DDMC_DEFINES_SVH

// =====================================================================
// Command word layout
`define DDMC_WORD_BITS 16
`define DDMC_BIT_CHSEL 15
`define DDMC_BIT_BUF 14
`define DDMC_BIT_GAIN 13
`define DDMC_BIT_PWR 12
`define DDMC_DATA_MSB 11
`define DDMC_CNT_W 5
`define DDMC_CNT_FULL 5'h10

// =====================================================================
// Reset values of the channel settings
`define DDMC_RST_GAIN 1'h0
`define DDMC_RST_BUF 1'h0
`define DDMC_RST_PWR 1'h0
`define DDMC_RST_CODE 12'h000

// =====================================================================
// Settling windows after leaving shutdown and in normal operation
`define DDMC_CLK_MHZ 100
`define DDMC_WAKE_NS 10000
`define DDMC_SETTLE_NS 4500
`define DDMC_WAKE_CYC ((`DDMC_WAKE_NS * `DDMC_CLK_MHZ) / 1000)
`define DDMC_SETTLE_CYC ((`DDMC_SETTLE_NS * `DDMC_CLK_MHZ) / 1000)

`endif

//--- rtl/ddmc_pkg.sv
package ddmc_pkg;
    // Serial receiver state
    typedef enum logic [1:0] {
        DDMC_IDLE,
        DDMC_SHIFT,
        DDMC_DONE
    } ddmc_rx_state_t;

    // Reference path of a channel
    typedef enum logic {
        DDMC_REF_UNBUF,
        DDMC_REF_BUF
    } ddmc_ref_t;
endpackage

//--- rtl/ddmc_channel.sv
`timescale 1ns/10ps
`include "ddmc_defines.svh"

module ddmc_channel #(
    parameter int CODE_W = 12,
    parameter int WAKE_CYC = `DDMC_WAKE_CYC,
    parameter int SETTLE_CYC = `DDMC_SETTLE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [CODE_W-1:0] code_in,
    input wire logic gain_in,
    input wire logic buf_in,
    input wire logic power_down_ctl_in,
    input wire logic hw_off_in,
    output logic [CODE_W-1:0] code_out,
    output logic unity_gain_out,
    output ddmc_pkg::ddmc_ref_t ref_mode_out,
    output logic active_out,
    output logic load_sel_out,
    output logic settling_out
);
    import ddmc_pkg::*;

    localparam int CNT_W = $clog2(WAKE_CYC + 1);

    logic [CNT_W-1:0] settle_reg;
    logic sw_on_reg;
    logic active_next;
    logic active_out_d;

    // =================================================================
    // Output register: code and settings latch together
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_out <= '0;
            unity_gain_out <= `DDMC_RST_GAIN;
            ref_mode_out <= DDMC_REF_UNBUF;
            sw_on_reg <= `DDMC_RST_PWR;
        end else if (load_in) begin
            code_out <= code_in;
            unity_gain_out <= gain_in;
            ref_mode_out <= ddmc_ref_t'(buf_in);
            sw_on_reg <= power_down_ctl_in;
        end
    end

    // =================================================================
    // Active when software enabled and the shutdown pin is high
    assign active_next = sw_on_reg & ~hw_off_in;
    assign active_out = active_next;
    assign load_sel_out = ~active_next;

    // =================================================================
    // Settling window: long after wake-up, short after a code change
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_reg <= '0;
        end else if (!active_next) begin
            settle_reg <= '0;
        end else if (!active_out_d) begin
            settle_reg <= CNT_W'(WAKE_CYC);
        end else if (load_in && code_in != code_out
                     && settle_reg < CNT_W'(SETTLE_CYC)) begin
            // A held strobe repeats loads; only a new code re-arms
            settle_reg <= CNT_W'(SETTLE_CYC);
        end else if (settle_reg != '0) begin
            settle_reg <= settle_reg - CNT_W'(1);
        end
    end

    // Previous activity, to spot the wake-up
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            active_out_d <= 1'b0;
        end else begin
            active_out_d <= active_next;
        end
    end

    assign settling_out = (settle_reg != '0);
endmodule

//--- rtl/ddmc_top.sv
// Contract
// - Channel code is unsigned binary of 8, 10 or 12 bits.
// - Gain bit one selects unity gain, zero selects double gain.
// - After reset each channel defaults to double gain.
// - Per-channel bit selects buffered or unbuffered reference.
// - Power-on reset puts both channels in shutdown.
// - Outputs stay off until a valid write and strobe low.
// - Undervoltage holds channels in reset until a later write.
// - Software shuts one channel; shutdown pin low shuts both.
// - Serial interface keeps decoding writes during shutdown.
// - Channel wakes on pin high or latched write with control one.
// - Supply monitor disabled in pin shutdown, enabled otherwise.
// - Shut channel gives no output, pin switched to resistive load.
// - Wake-up settling up to 10 us, normal settling 4.5 us.
// - Word: bit 15 channel B, 14 buffer, 13 gain, 12 power.
// - Data sampled on rising serial clock while select is low.
// - Word loaded on select rise only after exactly 16 clocks; the code also accepts more than 16, keeping the first 16 bits.
// - Strobe low copies both input registers to output registers.
`timescale 1ns/10ps
`include "ddmc_defines.svh"

module ddmc_top #(
    parameter int RES_BITS = 12,
    parameter int WAKE_CYC = `DDMC_WAKE_CYC,
    parameter int SETTLE_CYC = `DDMC_SETTLE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic undervolt_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_sdi_in,
    input wire logic output_latch_strobe_n_in,
    input wire logic hw_shutdown_n_in,
    output logic [RES_BITS-1:0] code_a_out,
    output logic [RES_BITS-1:0] code_b_out,
    output logic unity_gain_a_out,
    output logic unity_gain_b_out,
    output ddmc_pkg::ddmc_ref_t ref_mode_a_out,
    output ddmc_pkg::ddmc_ref_t ref_mode_b_out,
    output logic active_a_out,
    output logic active_b_out,
    output logic load_sel_a_out,
    output logic load_sel_b_out,
    output logic settling_a_out,
    output logic settling_b_out,
    output logic monitor_en_out,
    output logic word_taken_out
);
    import ddmc_pkg::*;

    // Unused low bits of the data field for narrow variants
    localparam int PAD_W = `DDMC_DATA_MSB + 1 - RES_BITS;

    // =================================================================
    // Input synchronisers
    logic [1:0] cs_sync_reg, sck_sync_reg, sdi_sync_reg;
    logic [1:0] output_latch_strobe_sync_reg, power_down_ctl_sync_reg, uv_sync_reg;
    logic sck_prev_reg, cs_prev_reg;
    logic cs_n, sck, sdi, strobe_n, hw_off, uv;

    // Two flops per outside input
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
            output_latch_strobe_sync_reg <= 2'h3;
            power_down_ctl_sync_reg <= 2'h3;
            uv_sync_reg <= 2'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_in};
            sck_sync_reg <= {sck_sync_reg[0], spi_sck_in};
            sdi_sync_reg <= {sdi_sync_reg[0], spi_sdi_in};
            output_latch_strobe_sync_reg <= {output_latch_strobe_sync_reg[0], output_latch_strobe_n_in};
            power_down_ctl_sync_reg <= {power_down_ctl_sync_reg[0], hw_shutdown_n_in};
            uv_sync_reg <= {uv_sync_reg[0], undervolt_in};
        end
    end

    assign cs_n = cs_sync_reg[1];
    assign sck = sck_sync_reg[1];
    assign sdi = sdi_sync_reg[1];
    assign strobe_n = output_latch_strobe_sync_reg[1];
    assign hw_off = ~power_down_ctl_sync_reg[1];
    assign uv = uv_sync_reg[1];

    // Edge history of the synchronised serial clock and select lines
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck;
            cs_prev_reg <= cs_n;
        end
    end

    logic sck_rise, cs_rise;
    assign sck_rise = sck & ~sck_prev_reg;
    assign cs_rise = cs_n & ~cs_prev_reg;

    // =================================================================
    // Supply monitor and internal reset
    logic chan_rst;
    // Monitor is off only while the shutdown pin holds the part
    assign monitor_en_out = ~hw_off;
    assign chan_rst = rst_in | (uv & monitor_en_out);

    // =================================================================
    // Serial receiver
    ddmc_rx_state_t rx_state_reg;
    logic [`DDMC_WORD_BITS-1:0] shift_reg;
    logic [`DDMC_CNT_W-1:0] bit_cnt_reg;
    logic word_ok;

    // Shift on rising serial clock while select low, ignoring extras
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_state_reg <= DDMC_IDLE;
            shift_reg <= '0;
            bit_cnt_reg <= '0;
        end else begin
            case (rx_state_reg)
                DDMC_IDLE: begin
                    bit_cnt_reg <= '0;
                    if (!cs_n) begin
                        rx_state_reg <= DDMC_SHIFT;
                    end
                end
                DDMC_SHIFT: begin
                    if (cs_n) begin
                        rx_state_reg <= DDMC_IDLE;
                    end else if (sck_rise) begin
                        shift_reg <= {shift_reg[`DDMC_WORD_BITS-2:0], sdi};
                        bit_cnt_reg <= bit_cnt_reg + `DDMC_CNT_W'(1);
                        if (bit_cnt_reg == `DDMC_CNT_FULL - 5'h01) begin
                            rx_state_reg <= DDMC_DONE;
                        end
                    end
                end
                DDMC_DONE: begin
                    if (cs_n) begin
                        rx_state_reg <= DDMC_IDLE;
                    end
                end
                default: rx_state_reg <= DDMC_IDLE;
            endcase
        end
    end

    assign word_ok = cs_rise && (rx_state_reg == DDMC_DONE);
    assign word_taken_out = word_ok;

    // =================================================================
    // Input registers, one per channel
    logic [RES_BITS-1:0] in_code_reg [2];
    logic [1:0] in_gain_reg, in_buf_reg, in_pwr_reg;
    logic any_write_reg;
    logic sel_b;

    assign sel_b = shift_reg[`DDMC_BIT_CHSEL];

    // Load the addressed input register from a complete word
    always_ff @(posedge clk_in or posedge chan_rst) begin
        if (chan_rst) begin
            for (int i = 0; i < 2; i++) begin
                in_code_reg[i] <= '0;
            end
            in_gain_reg <= {2{`DDMC_RST_GAIN}};
            in_buf_reg <= {2{`DDMC_RST_BUF}};
            in_pwr_reg <= {2{`DDMC_RST_PWR}};
            any_write_reg <= 1'b0;
        end else if (word_ok) begin
            in_code_reg[sel_b] <= shift_reg[`DDMC_DATA_MSB -: RES_BITS];
            in_gain_reg[sel_b] <= shift_reg[`DDMC_BIT_GAIN];
            in_buf_reg[sel_b] <= shift_reg[`DDMC_BIT_BUF];
            in_pwr_reg[sel_b] <= shift_reg[`DDMC_BIT_PWR];
            any_write_reg <= 1'b1;
        end
    end

    // =================================================================
    // Transfer: strobe low copies both channels at once
    logic xfer;
    assign xfer = ~strobe_n & any_write_reg;

    ddmc_channel #(
        .CODE_W(RES_BITS),
        .WAKE_CYC(WAKE_CYC),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_chan_a (
        .clk_in(clk_in),
        .rst_in(chan_rst),
        .load_in(xfer),
        .code_in(in_code_reg[0]),
        .gain_in(in_gain_reg[0]),
        .buf_in(in_buf_reg[0]),
        .power_down_ctl_in(in_pwr_reg[0]),
        .hw_off_in(hw_off),
        .code_out(code_a_out),
        .unity_gain_out(unity_gain_a_out),
        .ref_mode_out(ref_mode_a_out),
        .active_out(active_a_out),
        .load_sel_out(load_sel_a_out),
        .settling_out(settling_a_out)
    );

    ddmc_channel #(
        .CODE_W(RES_BITS),
        .WAKE_CYC(WAKE_CYC),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_chan_b (
        .clk_in(clk_in),
        .rst_in(chan_rst),
        .load_in(xfer),
        .code_in(in_code_reg[1]),
        .gain_in(in_gain_reg[1]),
        .buf_in(in_buf_reg[1]),
        .power_down_ctl_in(in_pwr_reg[1]),
        .hw_off_in(hw_off),
        .code_out(code_b_out),
        .unity_gain_out(unity_gain_b_out),
        .ref_mode_out(ref_mode_b_out),
        .active_out(active_b_out),
        .load_sel_out(load_sel_b_out),
        .settling_out(settling_b_out)
    );
endmodule

//--- test/ddmc_checker.sv
`timescale 1ns/10ps
// =====================================================================
// Port checker
module ddmc_checker #(
    parameter int RES_BITS = 12,
    parameter int WAKE_CYC = 1000
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic spi_cs_n_in,
    input wire logic output_latch_strobe_n_in,
    input wire logic hw_shutdown_n_in,
    input wire logic [RES_BITS-1:0] code_a_out,
    input wire logic unity_gain_a_out,
    input wire logic active_a_out,
    input wire logic active_b_out,
    input wire logic load_sel_a_out,
    input wire logic settling_a_out,
    input wire logic monitor_en_out,
    input wire logic word_taken_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic seen_reg;
    int unsigned run_reg;
    // Remembers any accepted word since reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) seen_reg <= 1'b0;
        else if (word_taken_out) seen_reg <= 1'b1;
    end
    // Counts the cycles of the current settling window
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) run_reg <= 0;
        else run_reg <= settling_a_out ? run_reg + 1 : 0;
    end
    a_reset_off: assert property ($fell(rst_in) |-> !active_a_out
        && !unity_gain_a_out && load_sel_a_out) else $error("not off");
    a_no_write: assert property (!seen_reg |->
        !active_a_out && !active_b_out) else $error("on before write");
    a_load_inv: assert property (load_sel_a_out == !active_a_out)
        else $error("load select wrong");
    a_pin_off: assert property (!hw_shutdown_n_in [*4] |->
        !active_a_out && !active_b_out) else $error("pin did not shut");
    a_mon_off: assert property (!hw_shutdown_n_in [*4] |->
        !monitor_en_out) else $error("monitor on in pin shutdown");
    a_mon_on: assert property (hw_shutdown_n_in [*4] |->
        monitor_en_out) else $error("monitor off");
    a_pulse_one: assert property (word_taken_out |=>
        !word_taken_out) else $error("word pulse too long");
    a_after_cs: assert property (word_taken_out |->
        $past(spi_cs_n_in, 2)) else $error("word taken with select low");
    a_code_strobe: assert property ($changed(code_a_out) &&
        code_a_out != 0 |-> !$past(output_latch_strobe_n_in, 2) ||
        !$past(output_latch_strobe_n_in, 3) ||
        !$past(output_latch_strobe_n_in, 4)) else $error("code moved");
    a_wake_settle: assert property ($rose(active_a_out) |->
        ##[0:1] settling_a_out) else $error("no settle on wake");
    a_settle_max: assert property (settling_a_out |->
        run_reg <= WAKE_CYC) else $error("settle too long");
endmodule

bind ddmc_top ddmc_checker #(.RES_BITS(RES_BITS), .WAKE_CYC(WAKE_CYC)) u_chk (
    .clk_in, .rst_in, .spi_cs_n_in, .output_latch_strobe_n_in,
    .hw_shutdown_n_in, .code_a_out, .unity_gain_a_out, .active_a_out,
    .active_b_out, .load_sel_a_out, .settling_a_out, .monitor_en_out,
    .word_taken_out);

//--- test/ddmc_host_model.sv
`timescale 1ns/10ps
// =====================================================================
// Serial host: clock idles low outside frames
module ddmc_host_model (
    output logic spi_cs_n_out,
    output logic spi_sck_out,
    output logic spi_sdi_out
);
    // Idle levels at time zero
    initial begin
        spi_cs_n_out = 1'b1;
        spi_sck_out = 1'b0;
        spi_sdi_out = 1'b0;
    end
    // Sends n clocks, MSB first; bits past 16 carry filler
    task automatic send(input logic [15:0] w, input int n);
        spi_cs_n_out = 1'b0;
        #1; // Keeps serial edges clear of the sampling clock edge
        for (int i = 0; i < n; i++) begin
            spi_sdi_out = (i < 16) ? w[15-i] : ~spi_sdi_out;
            #62.5 spi_sck_out = 1'b1;
            #62.5 spi_sck_out = 1'b0;
        end
        #62.5 spi_cs_n_out = 1'b1;
        spi_sdi_out = ~spi_sdi_out; // Released line shows no stale bit
        #250;
    endtask
endmodule

//--- test/ddmc_top_tb_top.sv
`timescale 1ns/10ps
// =====================================================================
// Testbench
module ddmc_top_tb_top;
    import ddmc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic undervolt_in = 1'b0;
    logic strobe_n = 1'b1;
    logic hw_n = 1'b1;
    logic cs_n, sck, sdi, ug_a, ug_b, act_a, act_b, ls_a, ls_b, st_a, mon;
    logic taken, st_b;
    logic [11:0] code_a, code_b;
    ddmc_ref_t ref_a, ref_b;
    int failures = 0;
    int n_checks = 0;
    int n_taken = 0;
    wire logic [3:0] flg_a = {ug_a, ref_a, act_a, ls_a};
    wire logic [3:0] flg_b = {ug_b, ref_b, act_b, ls_b};
    ddmc_top #(.RES_BITS(12), .WAKE_CYC(20), .SETTLE_CYC(9)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .undervolt_in(undervolt_in),
        .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_sdi_in(sdi),
        .output_latch_strobe_n_in(strobe_n), .hw_shutdown_n_in(hw_n),
        .code_a_out(code_a), .code_b_out(code_b),
        .unity_gain_a_out(ug_a), .unity_gain_b_out(ug_b),
        .ref_mode_a_out(ref_a), .ref_mode_b_out(ref_b),
        .active_a_out(act_a), .active_b_out(act_b),
        .load_sel_a_out(ls_a), .load_sel_b_out(ls_b),
        .settling_a_out(st_a), .settling_b_out(st_b),
        .monitor_en_out(mon), .word_taken_out(taken));
    ddmc_host_model u_host (.spi_cs_n_out(cs_n), .spi_sck_out(sck),
        .spi_sdi_out(sdi));
    // Clock and word counter
    always #5 clk_in = ~clk_in;
    always @(negedge clk_in) if (taken === 1'b1) n_taken++;
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flg(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr(input logic [15:0] w, input int n);
        u_host.send(w, n);
        cyc(8);
    endtask
    // Holds the transfer strobe low for a few cycles
    task automatic xfer();
        strobe_n = 1'b0;
        cyc(6);
        strobe_n = 1'b1;
        cyc(2);
    endtask
    // Watchdog
    initial begin
        #300000;
        failures++;
        give_verdict();
    end
    // Main sequence; flags are unity, buffered, active, load
    initial begin
        cyc(10);
        rst_in = 1'b0;
        cyc(4);
        chk_code(code_a, 12'h000);
        chk_flg(flg_a, 4'h1);
        chk_flg(flg_b, 4'h1);
        wr(16'h7ABC, 16);
        chk_code(12'(n_taken), 12'h001);
        chk_flg(flg_a, 4'h1);
        xfer();
        chk_code(code_a, 12'hABC);
        chk_flg(flg_a, 4'hE);
        chk_flg({3'h0, st_a}, 4'h1);
        cyc(10);
        chk_flg({3'h0, st_a}, 4'h1);
        cyc(15);
        chk_flg({3'h0, st_a}, 4'h0);
        wr(16'h9FFF, 15);
        wr(16'h9123, 17);
        chk_code(12'(n_taken), 12'h002);
        xfer();
        chk_code(code_b, 12'h123);
        chk_flg(flg_b, 4'h2);
        chk_flg({3'h0, st_b}, 4'h1);
        chk_code(code_a, 12'hABC);
        wr(16'h6055, 16);
        xfer();
        chk_code(code_a, 12'h055);
        chk_flg(flg_a, 4'hD);
        chk_flg(flg_b, 4'h2);
        chk_flg({3'h0, mon}, 4'h1);
        hw_n = 1'b0;
        cyc(4);
        chk_flg(flg_b, 4'h1);
        chk_flg({3'h0, mon}, 4'h0);
        wr(16'h30F0, 16);
        xfer();
        chk_code(code_a, 12'h0F0);
        chk_flg(flg_a, 4'h9);
        hw_n = 1'b1;
        cyc(4);
        chk_flg(flg_a, 4'hA);
        chk_flg(flg_b, 4'h2);
        undervolt_in = 1'b1;
        cyc(4);
        undervolt_in = 1'b0;
        cyc(4);
        chk_code(code_a, 12'h000);
        chk_flg(flg_b, 4'h1);
        xfer();
        chk_flg(flg_a, 4'h1);
        wr(16'h3456, 16);
        xfer();
        chk_code(code_a, 12'h456);
        give_verdict();
    end
endmodule
